// >>> dstc_consts.svh
// Constants for the self-test command handler
`ifndef DSTC_CONSTS_SVH
`define DSTC_CONSTS_SVH

`define DSTC_CMD_DISABLE 4'hc
`define DSTC_CMD_ENABLE 4'hd
`define DSTC_CMD_UNUSED14 4'he
`define DSTC_CMD_UNUSED15 4'hf
`define DSTC_ADDR_GLOBAL 4'h0
`define DSTC_DISABLE_LOCK_COUNT 2'h2
`define DSTC_RSP_FLAG_LSB 1
`define DSTC_RSP_ADDR_LSB 12

`endif

// >>> dstc_decode.sv
// Command decoder for the self-test commands
`timescale 1ns/100ps
`include "dstc_consts.svh"
module dstc_decode (
  input wire dstc_pkg::dstc_cmd_s i_cmd,
  input wire logic [3:0] i_bus_address,
  output logic o_is_disable,
  output logic o_is_enable,
  output logic o_is_other_valid,
  output logic o_is_global
);
  wire addr_hit;
  wire addr_global;
  wire upstream;
  assign upstream = !i_cmd.from_downstream;
  assign addr_global = (i_cmd.addr == `DSTC_ADDR_GLOBAL);
  assign addr_hit = (i_cmd.addr == i_bus_address);
  assign o_is_global = addr_global;
  // Disable accepted at own or global address, either format
  assign o_is_disable = upstream && (i_cmd.code == `DSTC_CMD_DISABLE)
    && (addr_hit || addr_global);
  // Enable never at global address
  assign o_is_enable = upstream && (i_cmd.code == `DSTC_CMD_ENABLE)
    && addr_hit && !addr_global;
  assign o_is_other_valid = upstream && addr_hit
    && (i_cmd.code != `DSTC_CMD_DISABLE) && (i_cmd.code != `DSTC_CMD_ENABLE)
    && (i_cmd.code != `DSTC_CMD_UNUSED14)
    && (i_cmd.code != `DSTC_CMD_UNUSED15);
endmodule

// >>> dstc_handler.sv
// Self-test command handler top level
`timescale 1ns/100ps
`include "dstc_consts.svh"
module dstc_handler (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire dstc_pkg::dstc_cmd_s i_cmd,
  input wire logic i_clear_cmd,
  input wire logic i_regulator_uv_reset,
  input wire logic i_frame_timeout_reset,
  input wire logic [3:0] i_bus_address,
  input wire logic i_reservoir_cap_low,
  input wire logic i_internal_error,
  input wire logic i_bus_switch_close,
  input wire logic i_otp_program_enable,
  input wire logic [7:0] i_device_config_register,
  output logic o_self_test_excite,
  output logic o_lockout,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_word
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Lockout threshold test
  function automatic logic at_lock_count(
    input logic [1:0] count
  );
    logic result;
    result = (count == `DSTC_DISABLE_LOCK_COUNT);
    return result;
  endfunction

  // Next consecutive-disable count, restart beats advance
  function automatic logic [1:0] count_step(
    input logic [1:0] count,
    input logic restart,
    input logic advance
  );
    logic [1:0] result;
    result = count;
    if (restart) begin
      result = 2'h0;
    end else if (advance) begin
      result = count + 2'h1;
    end
    return result;
  endfunction

  // Next lockout latch, clear beats set
  function automatic logic lock_step(
    input logic lock,
    input logic clear,
    input logic set_req
  );
    logic result;
    result = lock || set_req;
    if (clear) begin
      result = 1'b0;
    end
    return result;
  endfunction

  // Next excitation level, stop beats start
  function automatic logic excite_step(
    input logic level,
    input logic stop,
    input logic start
  );
    logic result;
    result = level;
    if (stop) begin
      result = 1'b0;
    end else if (start) begin
      result = 1'b1;
    end
    return result;
  endfunction

  // Response state after a decoded command
  function automatic dstc_pkg::dstc_state_e rsp_step(
    input logic answer,
    input logic quiet
  );
    dstc_pkg::dstc_state_e result;
    result = dstc_pkg::DSTC_IDLE;
    if (answer) begin
      result = dstc_pkg::DSTC_RESPOND;
    end else if (quiet) begin
      result = dstc_pkg::DSTC_DECODE;
    end
    return result;
  endfunction

  // ---------------------------------------------------------------
  // Synchronise asynchronous level inputs
  // ---------------------------------------------------------------
  logic uv_meta;
  logic uv_sync;
  logic err_meta;
  logic err_sync;

  // Reservoir-low level, two stages
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      uv_meta <= 1'b0;
      uv_sync <= 1'b0;
    end else begin
      uv_meta <= i_reservoir_cap_low;
      uv_sync <= uv_meta;
    end
  end

  // Internal error level, two stages
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      err_meta <= 1'b0;
      err_sync <= 1'b0;
    end else begin
      err_meta <= i_internal_error;
      err_sync <= err_meta;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic is_disable;
  logic is_enable;
  logic is_other;
  logic is_global;
  dstc_decode u_decode (
    .i_cmd(i_cmd),
    .i_bus_address(i_bus_address),
    .o_is_disable(is_disable),
    .o_is_enable(is_enable),
    .o_is_other_valid(is_other),
    .o_is_global(is_global)
  );

  // Data field i_cmd.data is deliberately unused
  wire cmd_strobe;
  wire take_disable;
  wire take_enable;
  wire take_other;
  wire take_quiet;
  assign cmd_strobe = i_cmd_valid;
  assign take_disable = cmd_strobe && is_disable;
  assign take_enable = cmd_strobe && is_enable;
  assign take_other = cmd_strobe && is_other;
  assign take_quiet = take_disable && is_global;

  // ---------------------------------------------------------------
  // Lockout clear sources
  // ---------------------------------------------------------------
  wire clear_by_uv;
  wire clear_by_cmd;
  wire clear_by_regulator;
  wire clear_by_timeout;
  wire lock_clear;

  assign clear_by_uv = uv_sync;
  assign clear_by_cmd = i_clear_cmd;
  assign clear_by_regulator = i_regulator_uv_reset;
  assign clear_by_timeout = i_frame_timeout_reset;
  assign lock_clear = clear_by_uv || clear_by_cmd || clear_by_regulator
    || clear_by_timeout;

  // ---------------------------------------------------------------
  // Consecutive-disable counter
  // ---------------------------------------------------------------
  logic [1:0] disable_count;
  logic [1:0] next_disable_count;
  wire count_full;
  wire count_restart;
  wire count_advance;
  wire reach_lock;

  assign count_full = at_lock_count(disable_count);
  assign count_restart = take_other || take_enable || lock_clear;
  assign count_advance = take_disable && !count_full;
  assign next_disable_count = count_step(disable_count, count_restart, count_advance);
  assign reach_lock = at_lock_count(next_disable_count);

  // Count register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      disable_count <= 2'h0;
    end else begin
      disable_count <= next_disable_count;
    end
  end

  // ---------------------------------------------------------------
  // Lockout latch
  // ---------------------------------------------------------------
  logic lockout;
  logic next_lockout;

  assign next_lockout = lock_step(lockout, lock_clear, reach_lock);

  // Latch register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lockout <= 1'b0;
    end else begin
      lockout <= next_lockout;
    end
  end

  // ---------------------------------------------------------------
  // Self-test excitation
  // ---------------------------------------------------------------
  logic excite;
  logic next_excite;
  wire excite_stop;
  wire excite_start;

  assign excite_stop = take_disable || next_lockout;
  assign excite_start = take_enable;
  assign next_excite = excite_step(excite, excite_stop, excite_start);

  // Excitation register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      excite <= 1'b0;
    end else begin
      excite <= next_excite;
    end
  end

  // ---------------------------------------------------------------
  // Response flags
  // ---------------------------------------------------------------
  wire flag_otp;
  wire flag_uv;
  wire flag_active;
  wire flag_switch;
  wire [1:0] flag_attr;
  wire flag_error;

  assign flag_otp = i_otp_program_enable;
  assign flag_uv = uv_sync;
  assign flag_active = next_excite;
  assign flag_switch = i_bus_switch_close;
  assign flag_attr = i_device_config_register[1:0];
  assign flag_error = err_sync;

  dstc_pkg::dstc_flags_s flags;
  assign flags.otp_program_enable_flag = flag_otp;
  assign flags.undervoltage_flag = flag_uv;
  assign flags.self_test_active_flag = flag_active;
  assign flags.bus_switch_flag = flag_switch;
  assign flags.attribute_bits = flag_attr;
  assign flags.error_flag = flag_error;

  // ---------------------------------------------------------------
  // Response word
  // ---------------------------------------------------------------
  logic [15:0] rsp_word_c;
  wire rsp_long;
  assign rsp_long = i_cmd.long_fmt;
  dstc_response u_response (
    .i_flags(flags),
    .i_bus_address(i_bus_address),
    .i_long_fmt(rsp_long),
    .o_word(rsp_word_c)
  );

  // ---------------------------------------------------------------
  // Response sequencing
  // ---------------------------------------------------------------
  dstc_pkg::dstc_state_e rsp_state;
  dstc_pkg::dstc_state_e next_rsp_state;
  wire rsp_due;

  // Answer local enable and disable only, stay silent on global disable
  assign rsp_due = take_enable || (take_disable && !take_quiet);
  // Track how the last command was handled
  always_comb begin
    next_rsp_state = dstc_pkg::DSTC_IDLE;
    case (rsp_state)
      dstc_pkg::DSTC_IDLE: begin
        next_rsp_state = rsp_step(rsp_due, take_quiet);
      end
      dstc_pkg::DSTC_DECODE: begin
        next_rsp_state = rsp_step(rsp_due, take_quiet);
      end
      dstc_pkg::DSTC_RESPOND: begin
        next_rsp_state = rsp_step(rsp_due, take_quiet);
      end
      default: begin
        next_rsp_state = dstc_pkg::DSTC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rsp_state <= dstc_pkg::DSTC_IDLE;
    end else begin
      rsp_state <= next_rsp_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Word holds until the next answer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rsp_word <= 16'h0000;
    end else if (rsp_due) begin
      o_rsp_word <= rsp_word_c;
    end
  end

  assign o_rsp_valid = (rsp_state == dstc_pkg::DSTC_RESPOND);
  assign o_self_test_excite = excite;
  assign o_lockout = lockout;
endmodule

// >>> dstc_handler_monitor.sv
// Concurrent checks on the self-test command handler ports
`timescale 1ns/100ps
module dstc_handler_monitor (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire dstc_pkg::dstc_cmd_s i_cmd,
  input wire logic i_clear_cmd,
  input wire logic i_regulator_uv_reset,
  input wire logic i_frame_timeout_reset,
  input wire logic [3:0] i_bus_address,
  input wire logic i_reservoir_cap_low,
  input wire logic o_self_test_excite,
  input wire logic o_lockout,
  input wire logic o_rsp_valid,
  input wire logic [15:0] o_rsp_word
);
  wire up = i_cmd_valid && !i_cmd.from_downstream;
  wire clr = i_clear_cmd || i_regulator_uv_reset || i_frame_timeout_reset;
  wire take = up && i_cmd.addr == i_bus_address && i_cmd.addr != 4'h0
    && i_cmd.code[3:1] == 3'h6;
  wire en = take && i_cmd.code[0];
  wire gdis = up && i_cmd.addr == 4'h0 && i_cmd.code == 4'hc;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_dis;
    (gdis || (take && !en)) && !clr && !i_reservoir_cap_low &&
      !$past(i_reservoir_cap_low) && !$past(i_reservoir_cap_low, 2);
  endsequence
  AST_ENA: assert property (en && !o_lockout |=> o_rsp_valid && o_self_test_excite)
    else $error("enable lost");
  AST_LOCKED: assert property (en && o_lockout && !clr && !$past(i_reservoir_cap_low, 2) |=> !o_self_test_excite && !o_rsp_word[5])
    else $error("enable under lockout");
  AST_DIS: assert property (take && !en |=> o_rsp_valid && !o_self_test_excite)
    else $error("disable lost");
  AST_GLOBAL: assert property (gdis |=> !o_rsp_valid && !o_self_test_excite)
    else $error("global disable wrong");
  AST_IGNORE: assert property (i_cmd_valid && !take |=> !o_rsp_valid)
    else $error("ignored command answered");
  AST_LONG: assert property (take && i_cmd.long_fmt |=> o_rsp_word[15:8] == {i_bus_address, 4'h0})
    else $error("long word top bad");
  AST_LOCK: assert property (s_dis ##1 !i_cmd_valid && !clr ##1 s_dis |=> o_lockout)
    else $error("lockout not set");
  AST_CLR: assert property (clr |=> !o_lockout)
    else $error("lockout not cleared");
endmodule
bind dstc_handler dstc_handler_monitor u_mon (.*);

// >>> dstc_master_model.sv
// Bus master model issuing checked command frames
`timescale 1ns/100ps
module dstc_master_model (
  input wire logic i_clk,
  output logic o_cmd_valid,
  output dstc_pkg::dstc_cmd_s o_cmd
);
  initial begin
    o_cmd_valid = 1'h0;
    o_cmd = '1;
  end
  task send(input logic [3:0] code, a, input logic lng, dn);
    @(negedge i_clk);
    o_cmd_valid <= 1'h1;
    o_cmd <= '{{a, code} ^ 8'h5a, a, code, lng, dn};
    @(negedge i_clk);
    o_cmd_valid <= 1'h0;
    o_cmd <= dstc_pkg::dstc_cmd_s'(~o_cmd);
  endtask
endmodule

// >>> dstc_pkg.sv
// Types for the self-test command handler
package dstc_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic [3:0] addr;
    logic [3:0] code;
    logic long_fmt;
    logic from_downstream;
  } dstc_cmd_s;

  typedef struct packed {
    logic otp_program_enable_flag;
    logic undervoltage_flag;
    logic self_test_active_flag;
    logic bus_switch_flag;
    logic [1:0] attribute_bits;
    logic error_flag;
  } dstc_flags_s;

  typedef enum logic [1:0] {
    DSTC_IDLE,
    DSTC_DECODE,
    DSTC_RESPOND
  } dstc_state_e;

endpackage

// >>> dstc_response.sv
// Response word builder for the self-test commands
`timescale 1ns/100ps
`include "dstc_consts.svh"
module dstc_response (
  input wire dstc_pkg::dstc_flags_s i_flags,
  input wire logic [3:0] i_bus_address,
  input wire logic i_long_fmt,
  output logic [15:0] o_word
);
  wire [7:0] low_byte;
  wire [15:0] long_word;
  wire [15:0] short_word;
  assign low_byte = {i_flags, 1'b0};
  assign short_word = {8'h00, low_byte};
  assign long_word = {i_bus_address, 4'h0, low_byte};
  assign o_word = i_long_fmt ? long_word : short_word;
endmodule

// >>> testbench.sv
// Self-checking testbench for the self-test command handler
`timescale 1ns/100ps
module testbench;
  logic i_clk = 1'h0;
  logic i_reset_n, clr, ruv, fto, cap, err, bsw, otp, st, cv, lk, ex, rv;
  logic [7:0] cfg;
  logic [3:0] ba;
  logic [15:0] rw;
  dstc_pkg::dstc_cmd_s cmd;
  int fails = 0;
  int comparisons = 0;
  dstc_master_model m (.i_clk(i_clk), .o_cmd_valid(cv), .o_cmd(cmd));
  dstc_handler DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_valid(cv), .i_cmd(cmd),
    .i_clear_cmd(clr), .i_regulator_uv_reset(ruv), .i_frame_timeout_reset(fto),
    .i_bus_address(ba), .i_reservoir_cap_low(cap), .i_internal_error(err),
    .i_bus_switch_close(bsw), .i_otp_program_enable(otp), .i_device_config_register(cfg),
    .o_self_test_excite(ex), .o_lockout(lk), .o_rsp_valid(rv), .o_rsp_word(rw));
  task eq(input logic [15:0] g, e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Flags f: long format, downstream, response expected
  task c(input logic [3:0] code, a, input logic [2:0] f);
    m.send(code, a, f[2], f[1]);
    #1;
    eq(rv, f[0]);
    if (f[0]) eq(rw, {f[2] ? {ba, 4'h0} : 8'h00, otp, cap, st, bsw, cfg[1:0], err, 1'h0});
  endtask
  task finish_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #25 i_clk = ~i_clk;
  initial begin
    #200000;
    fails++;
    finish_test;
  end
  initial begin
    {clr, ruv, fto, cap, err, st, i_reset_n} = 7'h00;
    {bsw, otp, cfg, ba} = {2'h3, 8'h02, 4'h5};
    repeat (2) @(posedge i_clk);
    @(negedge i_clk) i_reset_n = 1'h1;
    eq({ex, lk, rv}, 3'h0);
    st = 1'h1;
    c(4'hd, ba, 3'h1);
    c(4'hd, ba, 3'h5);
    c(4'he, ba, 3'h4);
    c(4'hf, ba, 3'h0);
    c(4'hd, ba, 3'h2);
    c(4'hd, 4'h0, 3'h4);
    c(4'hc, 4'h3, 3'h0);
    eq(ex, 1'h1);
    st = 1'h0;
    c(4'hc, ba, 3'h5);
    eq(ex, 1'h0);
    c(4'h1, ba, 3'h0);
    c(4'hc, ba, 3'h1);
    eq(lk, 1'h0);
    c(4'hc, 4'h0, 3'h0);
    eq({lk, ex}, 2'h2);
    c(4'hd, ba, 3'h5);
    eq(ex, 1'h0);
    for (int i = 0; i < 4; i++) begin
      c(4'hc, ba, 3'h1);
      c(4'hc, ba, 3'h5);
      eq(lk, 1'h1);
      @(negedge i_clk) {clr, ruv, fto, cap} = 4'h8 >> i;
      repeat (4) @(negedge i_clk);
      {clr, ruv, fto, cap} = 4'h0;
      eq(lk, 1'h0);
      repeat (3) @(negedge i_clk);
    end
    ba = 4'h0;
    c(4'hd, 4'h0, 3'h4);
    eq(ex, 1'h0);
    ba = 4'h5;
    {cap, err} = 2'h3;
    repeat (3) @(negedge i_clk);
    c(4'hc, ba, 3'h5);
    finish_test;
  end
endmodule
